/* File: design/flash_program_erase_status.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module flash_program_erase_status #(
    parameter int PROG_LIMIT_CYC = flash_status_pkg::PROG_LIMIT_CYC_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire flash_status_pkg::mem_bus_t mem_bus_in,
    output logic [15:0] mem_rdata_out,
    input wire logic [15:0] pri_rdata_in,
    input wire logic [15:0] sec_rdata_in,
    input wire flash_status_pkg::engine_cmd_t engine_cmd_in,
    output flash_status_pkg::engine_req_t engine_req_out
);
    import flash_status_pkg::*;

    // ****************************************************
    // Reset and pin synchronisers
    // ****************************************************
    logic rst_meta;
    logic rst_n;
    mem_bus_t bus_meta;
    mem_bus_t bus;
    mem_bus_t bus_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bus_meta <= BUS_IDLE;
            bus <= BUS_IDLE;
            bus_q <= BUS_IDLE;
        end else begin
            bus_meta <= mem_bus_in;
            bus <= bus_meta;
            bus_q <= bus;
        end
    end

    logic rd_fall;
    logic wr_rise;
    logic [1:0] hit;
    logic [1:0] reset_cmd;
    assign rd_fall = bus_q.rd_n & ~bus.rd_n;
    assign wr_rise = ~bus_q.wr_n & bus.wr_n;
    assign hit[0] = |bus.pri_sel;
    assign hit[1] = |bus.sec_sel;
    // Only the low byte carries instruction codes
    assign reset_cmd[0] = wr_rise & hit[0] & ~bus.addr[0] & (bus.wdata[7:0] == RESET_CMD);
    assign reset_cmd[1] = wr_rise & hit[1] & ~bus.addr[0] & (bus.wdata[7:0] == RESET_CMD);

    // ****************************************************
    // Last write strobe, seen by the decoder's commands
    // ****************************************************
    logic [15:0] last_data;
    logic [NUM_PRI-1:0] last_pri;
    logic [NUM_SEC-1:0] last_sec;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            last_data <= '0;
            last_pri <= '0;
            last_sec <= '0;
        end else if (wr_rise) begin
            last_data <= bus.wdata;
            last_pri <= bus.pri_sel;
            last_sec <= bus.sec_sel;
        end
    end

    // ****************************************************
    // Register file
    // ****************************************************
    logic high_style;
    logic [NUM_PRI-1:0] prot_pri;
    logic [NUM_SEC-1:0] prot_sec;
    logic [NUM_PRI-1:0] emask_pri;
    logic [NUM_SEC-1:0] emask_sec;
    op_state_t state [2];
    logic [CNT_W-1:0] cnt [2];
    logic [1:0] win;
    logic [1:0] tgl;
    logic [1:0] pbit;
    logic [1:0] prog_go;
    logic [1:0] erase_go;
    logic [1:0] last_prot;
    logic [1:0] all_prot;
    logic [1:0] bulk_prot;
    logic [31:0] next_rdata;
    logic apb_access;

    assign last_prot[0] = |(last_pri & prot_pri);
    assign last_prot[1] = |(last_sec & prot_sec);
    assign all_prot[0] = ~|(emask_pri & ~prot_pri);
    assign all_prot[1] = ~|(emask_sec & ~prot_sec);
    assign bulk_prot[0] = &prot_pri;
    assign bulk_prot[1] = &prot_sec;
    assign apb_access = psel_in & penable_in & pready_out;

    always_comb begin
        next_rdata = '0;
        case (paddr_in)
            REG_CTRL: next_rdata[CTRL_HIGH_POS] = high_style;
            REG_PROT_PRI: next_rdata[NUM_PRI-1:0] = prot_pri;
            REG_PROT_SEC: next_rdata[NUM_SEC-1:0] = prot_sec;
            REG_STATUS: begin
                for (int i = 0; i < 2; i++) begin
                    next_rdata[i*STAT_STRIDE+STAT_BUSY_POS] = state[i] != idle;
                    next_rdata[i*STAT_STRIDE+STAT_ERR_POS] = state[i] == failed;
                    next_rdata[i*STAT_STRIDE+STAT_WIN_POS] = win[i];
                    next_rdata[i*STAT_STRIDE+STAT_TGL_POS] = tgl[i];
                end
            end
            default: next_rdata = '0;
        endcase
    end

    // Answer is prepared in the setup cycle, so every access takes one wait-free phase
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end else begin
            pready_out <= psel_in & ~penable_in;
            if (psel_in && !penable_in) begin
                prdata_out <= pwrite_in ? 32'h0 : next_rdata;
                pslverr_out <= !(paddr_in inside {REG_CTRL, REG_PROT_PRI, REG_PROT_SEC,
                    REG_STATUS});
            end else begin
                pslverr_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            high_style <= 1'b0;
            prot_pri <= '0;
            prot_sec <= '0;
        end else if (apb_access && pwrite_in) begin
            case (paddr_in)
                REG_CTRL: high_style <= pwdata_in[CTRL_HIGH_POS];
                REG_PROT_PRI: prot_pri <= pwdata_in[NUM_PRI-1:0];
                REG_PROT_SEC: prot_sec <= pwdata_in[NUM_SEC-1:0];
                default: high_style <= high_style;
            endcase
        end
    end

    // ****************************************************
    // Per-array operation tracking
    // ****************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                state[i] <= idle;
                cnt[i] <= '0;
            end
            win <= 2'h3;
            pbit <= 2'h0;
            prog_go <= 2'h0;
            erase_go <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                prog_go[i] <= 1'b0;
                erase_go[i] <= 1'b0;
                case (state[i])
                    idle: begin
                        win[i] <= 1'b1;
                        cnt[i] <= '0;
                        if (engine_cmd_in.prog_cmd[i] && !last_prot[i]) begin
                            pbit[i] <= high_style ? last_data[15] : last_data[7];
                            if (|(~(i == 0 ? pri_rdata_in : sec_rdata_in) & last_data)) begin
                                state[i] <= failed;
                            end else begin
                                state[i] <= programming;
                                prog_go[i] <= 1'b1;
                            end
                        end else if (engine_cmd_in.sector_cmd[i]) begin
                            state[i] <= erase_window;
                            win[i] <= 1'b0;
                            pbit[i] <= 1'b1;
                        end else if (engine_cmd_in.bulk_cmd[i]) begin
                            pbit[i] <= 1'b1;
                            state[i] <= bulk_prot[i] ? blank_erase : erasing;
                            erase_go[i] <= !bulk_prot[i];
                        end
                    end
                    programming: begin
                        cnt[i] <= cnt[i] + 1'b1;
                        if (engine_cmd_in.fail[i] || cnt[i] == CNT_W'(PROG_LIMIT_CYC - 1)) begin
                            state[i] <= failed;
                        end else if (engine_cmd_in.done[i]) begin
                            state[i] <= idle;
                        end
                    end
                    erase_window: begin
                        cnt[i] <= cnt[i] + 1'b1;
                        if (reset_cmd[i]) begin
                            state[i] <= idle;
                        end else if (engine_cmd_in.sector_cmd[i]) begin
                            cnt[i] <= '0;
                            win[i] <= 1'b1;
                        end else if (cnt[i] == CNT_W'(WINDOW_CYC - 1)) begin
                            cnt[i] <= '0;
                            win[i] <= 1'b1;
                            state[i] <= all_prot[i] ? blank_erase : erasing;
                            erase_go[i] <= !all_prot[i];
                        end
                    end
                    erasing: begin
                        if (engine_cmd_in.fail[i]) begin
                            state[i] <= failed;
                        end else if (engine_cmd_in.done[i]) begin
                            state[i] <= idle;
                        end
                    end
                    blank_erase: begin
                        cnt[i] <= cnt[i] + 1'b1;
                        if (cnt[i] == CNT_W'(BLANK_CYC - 1)) begin
                            state[i] <= idle;
                        end
                    end
                    failed: begin
                        if (reset_cmd[i]) begin
                            state[i] <= idle;
                        end
                    end
                    default: state[i] <= idle;
                endcase
            end
        end
    end

    // Sectors gathered during the window; bulk erase takes the whole array
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            emask_pri <= '0;
            emask_sec <= '0;
        end else begin
            if (state[0] == idle && engine_cmd_in.bulk_cmd[0]) begin
                emask_pri <= '1;
            end else if (state[0] == idle && engine_cmd_in.sector_cmd[0]) begin
                emask_pri <= last_pri;
            end else if (state[0] == erase_window && engine_cmd_in.sector_cmd[0]) begin
                emask_pri <= emask_pri | last_pri;
            end
            if (state[1] == idle && engine_cmd_in.bulk_cmd[1]) begin
                emask_sec <= '1;
            end else if (state[1] == idle && engine_cmd_in.sector_cmd[1]) begin
                emask_sec <= last_sec;
            end else if (state[1] == erase_window && engine_cmd_in.sector_cmd[1]) begin
                emask_sec <= emask_sec | last_sec;
            end
        end
    end

    assign engine_req_out = '{prog_go: prog_go, erase_go: erase_go, pri_mask: emask_pri,
        sec_mask: emask_sec};

    // ****************************************************
    // Host read path
    // ****************************************************
    function automatic logic [15:0] status_word(input logic p, input logic t, input logic e,
        input logic w, input logic hi);
        logic [15:0] b;
        b = '0;
        b[POLL_POS] = p;
        b[TOGGLE_POS] = t;
        b[ERROR_POS] = e;
        b[WINDOW_POS] = w;
        return hi ? (b << HIGH_SHIFT) : b;
    endfunction

    logic sel;
    assign sel = ~hit[0] & hit[1];

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tgl <= 2'h0;
            mem_rdata_out <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (state[i] == idle || state[i] == blank_erase) begin
                    tgl[i] <= 1'b0;
                end else if (rd_fall && hit[i]) begin
                    tgl[i] <= ~tgl[i];
                end
            end
            if (rd_fall) begin
                if (!(|hit)) begin
                    mem_rdata_out <= '0;
                end else if (state[sel] == idle) begin
                    mem_rdata_out <= sel ? sec_rdata_in : pri_rdata_in;
                end else begin
                    // Reads only sample status, they never advance the operation
                    mem_rdata_out <= status_word(~pbit[sel] & (state[sel] != blank_erase),
                        tgl[sel] & (state[sel] != blank_erase), state[sel] == failed,
                        win[sel], high_style);
                end
            end
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    a_read_no_disturb: assert property (rd_fall && state[0] == erase_window && !reset_cmd[0]
        && cnt[0] < CNT_W'(WINDOW_CYC - 2) |=> state[0] == erase_window)
        else $error("read disturbed erase window");
    a_poll_inverse: assert property (rd_fall && hit[0] && state[0] == programming
        && !high_style |=> mem_rdata_out[POLL_POS] == ~pbit[0])
        else $error("poll bit not inverted while programming");
    a_poll_erase_low: assert property (rd_fall && hit[0] && state[0] == erasing
        && !high_style |=> !mem_rdata_out[POLL_POS])
        else $error("poll bit not zero during erase");
    a_high_lane_err: assert property (rd_fall && hit[0] && state[0] == failed && high_style
        |=> mem_rdata_out[ERROR_POS + HIGH_SHIFT] && !mem_rdata_out[ERROR_POS])
        else $error("error flag not in upper byte");
    a_toggle_flips: assert property (rd_fall && hit[0] && state[0] inside {programming,
        erasing, erase_window, failed} |=> tgl[0] != $past(tgl[0]))
        else $error("toggle bit did not invert");
    a_blank_length: assert property ($past(state[0]) == blank_erase && state[0] == idle
        |-> $past(cnt[0]) == CNT_W'(BLANK_CYC - 1))
        else $error("blank erase period wrong");
    a_window_restart: assert property (state[0] == erase_window && !reset_cmd[0]
        && engine_cmd_in.sector_cmd[0] |=> win[0] && cnt[0] == '0)
        else $error("window flag not set on extra command");
    a_error_clear: assert property ($past(state[0]) == failed && state[0] != failed
        |-> $past(reset_cmd[0]))
        else $error("error cleared without reset instruction");
    a_zero_to_one: assert property (state[0] == idle && engine_cmd_in.prog_cmd[0]
        && !last_prot[0] && |(~pri_rdata_in & last_data) |=> state[0] == failed)
        else $error("zero to one program not flagged");
    a_protect_ignore: assert property (state[0] == idle && engine_cmd_in.prog_cmd[0]
        && last_prot[0] |=> !prog_go[0] && state[0] != programming)
        else $error("protected program not ignored");
    a_idle_array: assert property (rd_fall && hit[1] && !hit[0] && state[1] == idle
        |=> mem_rdata_out == $past(sec_rdata_in))
        else $error("idle array did not return data");
endmodule

/* File: shared/flash_status_pkg.sv */
package flash_status_pkg;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    // Window between sector erase commands is 100 us plus 20 %
    localparam int WINDOW_US = 120;
    localparam int WINDOW_CYC = WINDOW_US * CYC_PER_US;
    localparam int BLANK_US = 100;
    localparam int BLANK_CYC = BLANK_US * CYC_PER_US;
    localparam int PROG_LIMIT_US = 1000;
    localparam int PROG_LIMIT_CYC_DEF = PROG_LIMIT_US * CYC_PER_US;
    localparam int CNT_W = 15;

    // ****************************************************
    // Status word layout
    // ****************************************************
    localparam int POLL_POS = 7;
    localparam int TOGGLE_POS = 6;
    localparam int ERROR_POS = 5;
    localparam int WINDOW_POS = 3;
    localparam int HIGH_SHIFT = 8;
    localparam logic [7:0] RESET_CMD = 8'hf0;
    localparam int NUM_PRI = 16;
    localparam int NUM_SEC = 4;

    // ****************************************************
    // Registers
    // ****************************************************
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_PROT_PRI = 12'h004;
    localparam logic [11:0] REG_PROT_SEC = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam int CTRL_HIGH_POS = 0;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_ERR_POS = 1;
    localparam int STAT_WIN_POS = 2;
    localparam int STAT_TGL_POS = 3;
    localparam int STAT_STRIDE = 4;

    // ****************************************************
    // Types
    // ****************************************************
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [NUM_PRI-1:0] pri_sel;
        logic [NUM_SEC-1:0] sec_sel;
    } mem_bus_t;

    localparam mem_bus_t BUS_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, default: '0};

    typedef struct packed {
        logic [1:0] prog_cmd;
        logic [1:0] sector_cmd;
        logic [1:0] bulk_cmd;
        logic [1:0] done;
        logic [1:0] fail;
    } engine_cmd_t;

    typedef struct packed {
        logic [1:0] prog_go;
        logic [1:0] erase_go;
        logic [NUM_PRI-1:0] pri_mask;
        logic [NUM_SEC-1:0] sec_mask;
    } engine_req_t;

    typedef enum logic [2:0] {
        idle, programming, erase_window, erasing, blank_erase, failed
    } op_state_t;

endpackage

/* File: verif/host_model.sv */
`timescale 1ns/1ps
module host_model
    import flash_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output mem_bus_t bus_out
);
    // ****************************************
    // Host bus cycles
    // ****************************************
    initial begin
        bus_out = BUS_IDLE;
    end
    task automatic cyc(input mem_bus_t b, input int n);
        bus_out <= b;
        repeat (n) @(posedge clk_in);
    endtask
    // One word per program write; strobes held past the sync stages
    task automatic wr(input logic [15:0] a, d, input logic [19:0] s);
        mem_bus_t b;
        b = '{1'b1, 1'b0, a, d, s[15:0], s[19:16]};
        cyc(b, 4);
        b.wr_n = 1'b1;
        cyc(b, 4);
        b = BUS_IDLE;
        // Released data lines do not keep the last value
        b.wdata = ~d;
        cyc(b, 1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [19:0] s, output logic [15:0] q);
        mem_bus_t b;
        b = '{1'b0, 1'b1, a, bus_out.wdata, s[15:0], s[19:16]};
        cyc(b, 4);
        q = rdata_in;
        b.rd_n = 1'b1;
        cyc(b, 3);
    endtask
endmodule

/* File: verif/test_flash_program_erase_status.sv */
`timescale 1ns/1ps
module test_flash_program_erase_status;
    import flash_status_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q32;
    logic [15:0] mrd, pri_d = 16'hffff, sec_d = 16'h5a5a, q1, q2;
    logic e;
    mem_bus_t bus;
    engine_cmd_t eng = '0;
    engine_req_t req, r;
    int n_errors = 0, num_checks = 0, cycles = 0;
    flash_program_erase_status #(.PROG_LIMIT_CYC(50)) uut (.sys_clk_in(clk), .rstn_in(rstn),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .mem_bus_in(bus), .mem_rdata_out(mrd), .pri_rdata_in(pri_d), .sec_rdata_in(sec_d),
        .engine_cmd_in(eng), .engine_req_out(req));
    host_model host (.clk_in(clk), .rdata_in(mrd), .bus_out(bus));
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q32 = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Command pulse; the go pulse is sampled in the one cycle it stands
    task automatic pulse(input engine_cmd_t c);
        eng <= c;
        @(posedge clk);
        eng <= '0;
        @(posedge clk);
        r = req;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        apb(0, REG_PROT_PRI, 0);
        chk(q32, 0);
        chk(e, 0);
        apb(0, 12'h010, 0);
        chk(q32, 0);
        chk(e, 1);
        apb(1, REG_PROT_PRI, 32'h1);
        apb(0, REG_PROT_PRI, 0);
        chk(q32, 32'h1);
    endtask
    task automatic t_prog();
        host.wr(16'h0002, 16'h1234, 20'h2);
        pulse('{prog_cmd: 2'b01, default: '0});
        chk(r.prog_go, 2'b01);
        host.rd(16'h0002, 20'h2, q1);
        host.rd(16'h0002, 20'h2, q2);
        chk(q1 & 16'h00a0, 16'h0080);
        chk(q2 & 16'hff17, 0);
        chk(q1[6] ^ q2[6], 1);
        host.rd(16'h0000, 20'h10000, q1);
        chk(q1, 16'h5a5a);
        pulse('{done: 2'b01, default: '0});
        pri_d <= 16'h1234;
        host.rd(16'h0002, 20'h2, q1);
        host.rd(16'h0002, 20'h2, q2);
        chk({q1, q2}, {2{16'h1234}});
    endtask
    task automatic t_fail();
        logic [19:0] s;
        for (int i = 0; i < 2; i++) begin
            // A sector that failed once is not used again
            s = i ? 20'h20 : 20'h2;
            pri_d <= i ? 16'hffff : 16'h0000;
            host.wr(16'h0002, i ? 16'h0000 : 16'hffff, s);
            pulse('{prog_cmd: 2'b01, default: '0});
            chk(r.prog_go, i ? 2'b01 : 2'b00);
            repeat (60) @(posedge clk);
            host.rd(16'h0002, s, q1);
            host.rd(16'h0002, s, q2);
            chk(q1 & q2 & 16'h0020, 16'h0020);
            apb(0, REG_STATUS, 0);
            chk(q32, 32'h47);
            apb(1, REG_CTRL, 32'h1);
            host.rd(16'h0002, s, q1);
            chk(q1 & 16'h2020, 16'h2000);
            apb(1, REG_CTRL, 0);
            host.wr(16'h0000, {8'h00, RESET_CMD}, s);
            host.rd(16'h0002, s, q1);
            chk(q1, pri_d);
        end
        host.wr(16'h0000, 16'h0000, 20'h1);
        pulse('{prog_cmd: 2'b01, default: '0});
        chk(r.prog_go, 0);
        host.rd(16'h0000, 20'h1, q1);
        chk(q1, pri_d);
    endtask
    task automatic t_erase();
        apb(1, REG_CTRL, 32'h1);
        host.wr(16'h0004, 16'h0030, 20'h4);
        pulse('{sector_cmd: 2'b01, default: '0});
        host.rd(16'h0004, 20'h4, q1);
        host.rd(16'h0006, 20'h4, q2);
        chk(q1 & 16'ha800, 0);
        chk(q2 & 16'h17ff, 0);
        chk(q1[14] ^ q2[14], 1);
        host.wr(16'h0008, 16'h0030, 20'h8);
        pulse('{sector_cmd: 2'b01, default: '0});
        chk({r.pri_mask, r.sec_mask}, {16'h000c, 4'h0});
        host.rd(16'h0008, 20'h8, q1);
        chk(q1 & 16'h0800, 16'h0800);
        repeat (2450) @(posedge clk);
        host.rd(16'h0004, 20'h4, q1);
        chk(q1 & 16'ha800, 16'h0800);
        apb(1, REG_CTRL, 0);
        host.rd(16'h0004, 20'h4, q1);
        chk(q1 & 16'h00a8, 16'h0008);
        pulse('{done: 2'b01, default: '0});
        pri_d <= 16'hffff;
        host.rd(16'h0004, 20'h4, q1);
        chk(q1, 16'hffff);
    endtask
    task automatic t_blank();
        apb(1, REG_PROT_PRI, 32'hffff);
        host.wr(16'h0000, 16'h0010, 20'h1);
        pulse('{bulk_cmd: 2'b01, default: '0});
        chk(r.erase_go, 0);
        host.rd(16'h0000, 20'h1, q1);
        host.rd(16'h0000, 20'h1, q2);
        chk(q1 & 16'h00c0, 0);
        chk(q2 & 16'h00c0, 0);
        repeat (2100) @(posedge clk);
        pri_d <= 16'h00a5;
        host.rd(16'h0000, 20'h1, q1);
        chk(q1, 16'h00a5);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_prog();
        t_fail();
        t_erase();
        t_blank();
        give_verdict();
    end
endmodule
